// ===== core/odt_pkg.sv
// shared constants and types for the termination control link
package odt_pkg;
	localparam int LAT_W = 5;
	localparam logic [LAT_W-1:0] LAT_OFFSET = 5'h02; // odt latency = wl - 2
	localparam logic [LAT_W-1:0] HOLD_BC4 = 5'h04;
	localparam logic [LAT_W-1:0] HOLD_BL8 = 5'h06;
	localparam int PIPE_D = 32;
	// analog delay in async mode, counted in clocks
	localparam logic [LAT_W-1:0] ASYNC_ON_CYC = 5'h01;
	localparam logic [LAT_W-1:0] ASYNC_OFF_CYC = 5'h01;
	// apb register offsets of the controller
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// cfg fields
	localparam int CFG_CWL_LSB = 0;
	localparam int CFG_AL_LSB = 5;
	localparam int CFG_RL_LSB = 10;
	localparam int CFG_NOM_BIT = 15;
	localparam int CFG_WR_LSB = 16;
	localparam int CFG_DLL_BIT = 18;
	localparam int CFG_PPD_BIT = 19;
	// cmd fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BL8_BIT = 2;
	typedef enum logic [1:0] {RTT_OFF, RTT_NOM, RTT_WR} rtt_t;
	typedef enum logic [1:0] {OP_NONE, OP_ODT_ON, OP_WRITE, OP_READ} op_t;
endpackage

// ===== core/odt_link_if.sv
// link between memory controller and termination block
`timescale 1ns/1ps
interface odt_link_if;
	logic odt;
	logic wr_cmd;
	logic wr_bl8;
	logic cke;
	modport ctrl (output odt, output wr_cmd, output wr_bl8, output cke);
	modport dev (input odt, input wr_cmd, input wr_bl8, input cke);
endinterface

// ===== core/odt_term_dev.sv
// device end: termination state from the odt pin and write commands
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - sync timing when dll locked, termination enabled
// - sync in active states and dll-on power-down
// - turn on/off odt latency after sampling
// - odt latency equals cwl plus al minus two
// - internal odt delayed by additive latency
// - controller holds odt high four cycles unless a read cmd drops it
// - write with odt holds four or six unless a read cmd drops it
// - later of both hold points governs release
// - odt low around read bursts
// - async in dll-off power-down and resync
// - async mode ignores latency, analog delay
// - dynamic switching when either wr bit set
// - write switches to write strength after wl-2
// - back to nominal after odtloff plus 6/4
module odt_term_dev
	import odt_pkg::*;
(
	input wire logic clock_in, // device clock
	input wire logic rst_n_in, // async reset, active low
	odt_link_if.dev link, // pins from controller
	input wire logic [4:0] cwl_in, // cas write latency
	input wire logic [4:0] al_in, // additive latency
	input wire logic rtt_nom_en_in, // nominal termination enabled
	input wire logic [1:0] rtt_wr_sel_in, // write termination select
	input wire logic dll_locked_in, // dll on and locked
	input wire logic ppd_dll_off_in, // dll off in precharge pd
	input wire logic all_banks_idle_in, // precharged state
	output rtt_t rtt_state_out, // resulting termination
	output logic sync_mode_out // synchronous timing active
);
	typedef struct packed {
		logic [PIPE_D-1:0] odt_pipe;
		logic [PIPE_D-1:0] wr_pipe;
		logic [LAT_W-1:0] wr_hold;
		logic [LAT_W-1:0] async_cnt;
		logic async_odt;
		logic odt_int;
		rtt_t rtt;
		logic sync;
		logic [PIPE_D-1:0] bl8_pipe;
		logic [2:0] pin_meta;
		logic [2:0] pin_sync;
	} state_t;

	state_t s_ff;
	state_t nxt_s;
	logic [LAT_W-1:0] odtl;
	logic [LAT_W-1:0] cnw;
	logic [LAT_W-1:0] wl;
	logic term_en;
	logic dyn_en;
	logic sync_now;
	logic odt_d;
	logic wr_d;
	logic bl8_d;
	logic dll_ok;
	logic ppd_off;
	logic banks_idle;

	//--------------------------------------------------
	// mode selection
	//--------------------------------------------------
	always_comb begin
		// status pins are read only after their second stage
		dll_ok = s_ff.pin_sync[0];
		ppd_off = s_ff.pin_sync[1];
		banks_idle = s_ff.pin_sync[2];
		wl = cwl_in + al_in;
		// a write latency below two would wrap; use the same-edge tap
		odtl = (wl < LAT_OFFSET) ? 5'h00 : wl - LAT_OFFSET;
		cnw = odtl;
		dyn_en = rtt_wr_sel_in != 2'h0;
		term_en = rtt_nom_en_in | dyn_en;
		// power-down with dll off, or relock, goes async
		sync_now = dll_ok & term_en &
			~(~link.cke & banks_idle & ppd_off);
	end

	//--------------------------------------------------
	// delayed odt and write taps
	//--------------------------------------------------
	always_comb begin
		// shift register; tap index zero means sampled this edge
		odt_d = (odtl == 5'h00) ? link.odt : s_ff.odt_pipe[odtl - 5'h01];
		wr_d = (cnw == 5'h00) ? link.wr_cmd : s_ff.wr_pipe[cnw - 5'h01];
		// burst length travels with its write, not the later pin level
		bl8_d = (cnw == 5'h00) ? link.wr_bl8 : s_ff.bl8_pipe[cnw - 5'h01];
	end

	always_comb begin
		nxt_s = s_ff;
		nxt_s.odt_pipe = {s_ff.odt_pipe[PIPE_D-2:0], link.odt};
		nxt_s.wr_pipe = {s_ff.wr_pipe[PIPE_D-2:0],
			link.wr_cmd & dyn_en};
		nxt_s.bl8_pipe = {s_ff.bl8_pipe[PIPE_D-2:0], link.wr_bl8};
		nxt_s.pin_meta = {all_banks_idle_in, ppd_dll_off_in, dll_locked_in};
		nxt_s.pin_sync = s_ff.pin_meta;
		nxt_s.sync = sync_now;
		// write strength lasts from odtlcnw to odtloff plus 4/6
		if (s_ff.wr_hold != 5'h00) begin
			nxt_s.wr_hold = s_ff.wr_hold - 5'h01;
		end
		if (sync_now && dyn_en && wr_d) begin
			// both bl8 and bc4 hold counted from the wl-2 tap
			nxt_s.wr_hold = bl8_d ? HOLD_BL8 : HOLD_BC4;
		end
		// async path: no additive latency, fixed analog delay
		if (link.odt != s_ff.async_odt) begin
			if (s_ff.async_cnt == 5'h00) begin
				nxt_s.async_odt = link.odt;
				nxt_s.async_cnt = link.odt ? ASYNC_ON_CYC : ASYNC_OFF_CYC;
			end else begin
				nxt_s.async_cnt = s_ff.async_cnt - 5'h01;
			end
		end else begin
			nxt_s.async_cnt = 5'h00;
		end
		nxt_s.odt_int = sync_now ? odt_d : s_ff.async_odt;
		if (!term_en || !nxt_s.odt_int) begin
			nxt_s.rtt = RTT_OFF;
		end else if (sync_now && dyn_en &&
			((wr_d) || s_ff.wr_hold > 5'h01)) begin
			nxt_s.rtt = RTT_WR;
		end else if (rtt_nom_en_in) begin
			nxt_s.rtt = RTT_NOM;
		end else begin
			nxt_s.rtt = RTT_OFF;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rtt_state_out = s_ff.rtt;
	assign sync_mode_out = s_ff.sync;
endmodule

// ===== core/odt_ctrl.sv
// controller end: schedules odt pin around writes and reads, apb slave
`timescale 1ns/1ps
module odt_ctrl
	import odt_pkg::*;
(
	input wire logic clock_in, // controller clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	odt_link_if.ctrl link // pins to device
);
	typedef struct packed {
		logic [31:0] cfg;
		logic odt;
		logic wr;
		logic bl8;
		logic [LAT_W-1:0] hold;
		logic [5:0] rd_block;
		logic [31:0] rdata;
		logic busy;
	} state_t;

	state_t s_ff;
	state_t nxt_s;
	logic acc;
	logic [LAT_W-1:0] hold_new;
	logic [5:0] rd_win;
	op_t op;

	always_comb begin
		acc = psel & penable;
		op = op_t'(pwdata[CMD_OP_LSB +: 2]);
		hold_new = pwdata[CMD_BL8_BIT] ? HOLD_BL8 : HOLD_BC4;
		// read window covers rl plus bl8 plus pre/post margin
		rd_win = {1'b0, s_ff.cfg[CFG_RL_LSB +: 5]} + 6'h06;
		nxt_s = s_ff;
		nxt_s.wr = 1'b0;
		nxt_s.rdata = 32'h0000_0000;
		if (s_ff.hold != 5'h00) begin
			nxt_s.hold = s_ff.hold - 5'h01;
		end
		if (s_ff.rd_block != 6'h00) begin
			nxt_s.rd_block = s_ff.rd_block - 6'h01;
		end
		if (acc && pwrite && paddr == REG_CFG) begin
			nxt_s.cfg = pwdata;
		end
		if (acc && pwrite && paddr == REG_CMD) begin
			case (op)
				OP_ODT_ON: begin
					if (s_ff.rd_block == 6'h00) begin
						nxt_s.odt = 1'b1;
						if (!s_ff.odt) begin
							nxt_s.hold = HOLD_BC4;
						end
					end
				end
				OP_WRITE: begin
					nxt_s.wr = 1'b1;
					nxt_s.bl8 = pwdata[CMD_BL8_BIT];
					if (s_ff.odt && hold_new > s_ff.hold) begin
						nxt_s.hold = hold_new;
					end
				end
				OP_READ: begin
					nxt_s.odt = 1'b0;
					nxt_s.rd_block = rd_win;
				end
				default: begin
					// release only when every hold has expired
					if (s_ff.hold <= 5'h01) begin
						nxt_s.odt = 1'b0;
					end
				end
			endcase
		end
		if (acc && !pwrite) begin
			case (paddr)
				REG_CFG: nxt_s.rdata = s_ff.cfg;
				REG_STAT: nxt_s.rdata = {16'h0000, s_ff.rd_block[5:0],
					s_ff.hold, 3'h0, s_ff.bl8, s_ff.odt};
				default: nxt_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_ff <= '0;
			s_ff.cfg <= CFG_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign pready = 1'b1;
	assign pslverr = acc && paddr != REG_CFG && paddr != REG_CMD &&
		paddr != REG_STAT;
	assign prdata = nxt_s.rdata;
	assign link.odt = s_ff.odt;
	assign link.wr_cmd = s_ff.wr;
	assign link.wr_bl8 = s_ff.bl8;
	assign link.cke = 1'b1;
endmodule

// ===== verification/odt_link_monitor.sv
// assertion checker for the termination control link
`timescale 1ns/1ps
module odt_link_monitor
	import odt_pkg::*;
(
	input wire logic clock_in, // link clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic odt, // termination pin
	input wire logic wr_cmd, // write pulse
	input wire logic wr_bl8, // burst length 8
	input wire logic cke, // clock enable
	input wire rtt_t rtt_state_out // device state
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	logic wr4_hi;
	logic wr8_hi;
	logic [6:0] low_ff;
	logic [6:0] nxt_low;
	assign wr4_hi = wr_cmd & !wr_bl8 & odt;
	assign wr8_hi = wr_cmd & wr_bl8 & odt;
	// saturates; 70 lies past the longest latency 31 - 2, as wl is five bits wide
	always_comb begin
		nxt_low = (low_ff == 7'h7f) ? low_ff : low_ff + 7'h01;
		if (odt) begin
			nxt_low = 7'h00;
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_ff <= 7'h00;
		end else begin
			low_ff <= nxt_low;
		end
	end
	sequence s_hold4;
		odt [*4];
	endsequence
	sequence s_hold6;
		odt [*6];
	endsequence
	chk_odt_min_high: assert property ($rose(odt) |-> s_hold4)
		else $error("odt released early");
	chk_bc4_hold: assert property (wr4_hi |-> s_hold4)
		else $error("odt low inside bc4 hold");
	chk_bl8_hold: assert property (wr8_hi |-> s_hold6)
		else $error("odt low inside bl8 hold");
	chk_later_release: assert property (
		$fell(odt) |-> !$past(wr8_hi, 5))
		else $error("odt released before write hold");
	chk_wr_pulse: assert property (wr_cmd |=> !wr_cmd)
		else $error("write pulse too long");
	chk_cke_high: assert property ($past(rst_n_in) |-> cke)
		else $error("cke low");
	chk_rtt_code: assert property (rtt_state_out != 2'h3)
		else $error("illegal termination code");
	chk_rtt_off_idle: assert property (
		low_ff >= 7'h46 |-> rtt_state_out == RTT_OFF)
		else $error("termination on with odt low");
endmodule

// ===== verification/ddr_odt_termination_control_tb_top.sv
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
module ddr_odt_termination_control_tb_top import odt_pkg::*;;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] cwl_in = 5'h08;
	logic [4:0] al_in = 5'h00;
	logic dll_locked_in = 1'b1;
	logic rtt_nom_en = 1'b0;
	logic [1:0] rtt_wr_sel = 2'h0;
	rtt_t rtt_state_out;
	logic sync_mode_out;
	logic [63:0] exp_q[$];
	logic [63:0] ent;
	logic [7:0] r = 8'h0e;
	logic [31:0] cfg;
	logic e;
	int n;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	odt_link_if link_if();
	odt_ctrl odt_ctrl_inst(.clock_in(clock_in), .rst_n_in(rst_n_in),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_if.ctrl));
	odt_term_dev odt_term_dev_inst(.clock_in(clock_in),
		.rst_n_in(rst_n_in), .link(link_if.dev), .cwl_in(cwl_in),
		.al_in(al_in), .rtt_nom_en_in(rtt_nom_en),
		.rtt_wr_sel_in(rtt_wr_sel),
		.dll_locked_in(dll_locked_in), .ppd_dll_off_in(1'b0),
		.all_banks_idle_in(1'b1), .rtt_state_out(rtt_state_out),
		.sync_mode_out(sync_mode_out));
	odt_link_monitor odt_link_monitor_inst(.clock_in(clock_in),
		.rst_n_in(rst_n_in), .odt(link_if.odt), .wr_cmd(link_if.wr_cmd),
		.wr_bl8(link_if.wr_bl8), .cke(link_if.cke),
		.rtt_state_out(rtt_state_out));
	always #20 clock_in = ~clock_in;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			num_errors++;
			$display("wrong value at %0t: %h vs %h", $time, g, x);
		end
	endtask
	task summarize;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		@(posedge clock_in);
		while (pready !== 1'b1) @(posedge clock_in);
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so a following call never reassigns psel here
		@(posedge clock_in);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		exp_q.push_back({m, x});
		apb(1'b0, a, 32'h0);
	endtask
	task cmd(input logic [2:0] c);
		apb(1'b1, REG_CMD, {29'h0, c});
	endtask
	task wrtt(input rtt_t x, input int lim);
		for (n = 0; n < lim && rtt_state_out !== x; n++) @(posedge clock_in);
		chk(32'(rtt_state_out), 32'(x));
	endtask
	// read results are matched against the oldest note
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			summarize();
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			ent = exp_q.pop_front();
			chk(prdata & ent[63:32], ent[31:0]);
		end
	end
	initial begin
		repeat (10) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		rd(REG_CFG, 32'hffffffff, CFG_RESET);
		r = lfsr(r);
		cfg = {12'h000, 4'h5, 1'b1, 5'h0b, 3'h0, r[1:0], 2'h1, r[4:2]};
		cwl_in <= cfg[4:0];
		al_in <= cfg[9:5];
		rtt_nom_en <= cfg[15];
		rtt_wr_sel <= cfg[17:16];
		apb(1'b1, REG_CFG, cfg);
		rd(REG_CFG, 32'h000fffff, cfg);
		apb(1'b1, 8'h0c, {24'h0, lfsr(r)});
		chk(32'(e), 32'h1);
		chk(32'(sync_mode_out), 32'h1);
		cmd(3'h1);
		cmd(3'h0);
		rd(REG_STAT, 32'h1, 32'h1);
		wrtt(RTT_NOM, 70);
		repeat (8) @(posedge clock_in);
		cmd(3'h0);
		wrtt(RTT_OFF, 70);
		for (int b = 0; b < 2; b++) begin
			cmd(3'h1);
			cmd({b[0], 2'h2});
			cmd(3'h0);
			wrtt(RTT_WR, 70);
			wrtt(RTT_NOM, 20);
			chk(32'(n), 32'(4 + 2 * b));
			cmd(3'h0);
			wrtt(RTT_OFF, 70);
		end
		cmd(3'h3);
		cmd(3'h1);
		rd(REG_STAT, 32'h1, 32'h0);
		repeat (80) @(posedge clock_in);
		dll_locked_in <= 1'b0;
		// two synchroniser stages plus the registered mode flag
		repeat (5) @(posedge clock_in);
		chk(32'(sync_mode_out), 32'h0);
		cmd(3'h1);
		wrtt(RTT_NOM, 4);
		summarize();
	end
endmodule
